// ### logic/wk_pkg.sv
/*
 * Shared constants for the wake event status and indication block:
 * register offsets, field positions, reset values, encodings and timing.
 * Assumes a single 10 MHz clock shared by both ends of the host bus.
 */
// Notes on behaviour
// - Wake cause: 01 energy, 10 frame, 11 both
// - Writing one clears a cause bit
// - Clearing works only when ready in full power
// - Cause bit stays while its source active
// - Pulse mode: output active for 50 ms
// - Static mode: output held until deactivated
// - Clearing causes or enables deactivates output
// - Polarity bit picks active level, resets zero
// - Open-drain buffer forces active low output
// - Output driven only while enable bit set
// - Output enable never gates wake interrupt
// - Read-only ready flag at bit zero
// - Power control register readable in every state
// - Host avoids other addresses while not ready
// - Host reads only config and power registers
// - Host issues soft reset only once ready
// - Power state: 00 full, 01 frame, 10 energy
// - Enabled events drive output and interrupt
// - Byte test write wakes; host writes nothing else
package wk_pkg;
	// ----------------------------------------------------------------
	// Register map
	// ----------------------------------------------------------------
	localparam logic [7:0] ADDR_BYTE_TEST = 8'h64;
	localparam logic [7:0] ADDR_HW_CONFIG = 8'h74;
	localparam logic [7:0] ADDR_POWER_CONTROL = 8'h84;
	localparam logic [31:0] BYTE_TEST_VALUE = 32'h8765_4321;

	// ----------------------------------------------------------------
	// Power control register fields, plus the hardware config soft reset bit
	// ----------------------------------------------------------------
	localparam int POS_READY = 0;
	localparam int POS_OUT_EN = 1;
	localparam int POS_POLARITY = 2;
	localparam int POS_PULSE_SEL = 3;
	localparam int POS_CAUSE = 4;
	localparam int POS_BUF_TYPE = 6;
	localparam int POS_ENERGY_DETECT_WAKE_ENABLE = 8;
	localparam int POS_LAN_WAKE_ENABLE = 9;
	localparam int POS_PSEL = 12;
	localparam int POS_SOFT_RESET = 0;

	typedef enum logic [1:0] {
		PSEL_FULL_POWER = 2'h0,
		PSEL_FRAME_WAKE = 2'h1,
		PSEL_ENERGY_DETECT = 2'h2,
		PSEL_RESERVED = 2'h3
	} wk_psel_type;

	localparam logic [1:0] CAUSE_ENERGY = 2'h1;
	localparam logic [1:0] CAUSE_FRAME = 2'h2;
	localparam logic [1:0] CAUSE_RESET = 2'h0;
	localparam logic CTRL_BIT_RESET = 1'h0;

	// ----------------------------------------------------------------
	// Timing
	// ----------------------------------------------------------------
	localparam int CLK_HZ = 10_000_000;
	localparam int WAKE_PULSE_MS = 50;
	localparam int WAKE_PULSE_CYCLES = WAKE_PULSE_MS * (CLK_HZ / 1000);
	localparam int SETTLE_CYCLES = 16;
endpackage

// ### logic/wk_bus_if.sv
/*
 * Host bus and wake pin between the host and the controller.
 * Assumes both ends share mclk and reset_n; the wake line has a pull-up.
 */
`timescale 1ns/1ps
interface wk_bus_if (
	input wire logic mclk,
	input wire logic reset_n
);
	logic req;
	logic we;
	logic [7:0] addr;
	logic [31:0] wdata;
	logic ack;
	logic [31:0] rdata;
	logic wake_out;
	logic wake_oe;
	logic wake_interrupt;
	logic wake_level;

	// Resolved wake line level, pulled up when nobody drives it
	assign wake_level = wake_oe ? wake_out : 1'b1;

	modport device (
		input mclk, reset_n, req, we, addr, wdata,
		output ack, rdata, wake_out, wake_oe, wake_interrupt
	);
	modport host (
		input mclk, reset_n, ack, rdata, wake_level, wake_interrupt,
		output req, we, addr, wdata
	);
endinterface

// ### logic/wk_device.sv
/*
 * Controller end: power control register, wake cause status,
 * wake event output shaping and the device ready flag.
 * Assumes the host presents one-cycle requests on the shared bus and
 * that the wake detectors deliver level event signals on mclk.
 */
`timescale 1ns/1ps
module wk_device #(
	parameter int PULSE_CYCLES = wk_pkg::WAKE_PULSE_CYCLES,
	parameter int SETTLE = wk_pkg::SETTLE_CYCLES
) (
	wk_bus_if.device bus,
	input wire logic lan_wake_event,
	input wire logic energy_event,
	input wire logic [31:0] hw_config_in,
	output logic [1:0] power_state_select,
	output logic soft_reset_request
);
	import wk_pkg::*;

	localparam int PW = $clog2(PULSE_CYCLES + 1);
	localparam int SW = $clog2(SETTLE + 1);

	logic ready_q;
	logic [SW-1:0] settle_q;
	logic [1:0] psel_q;
	logic lan_wake_enable_q;
	logic energy_detect_wake_enable_q;
	logic wake_output_buffer_type_q;
	logic wake_output_pulse_select_q;
	logic wake_output_polarity_q;
	logic wake_output_enable_q;
	logic [1:0] wake_cause_status_q;
	logic [1:0] wake_cause_status_d;
	logic [PW-1:0] pulse_q;
	logic [1:0] source_q;
	logic ack_q;
	logic [31:0] rdata_q;
	logic soft_reset_q;
	logic [1:0] source;
	logic [1:0] armed;
	logic [1:0] armed_d;
	logic detect;
	logic wr;
	logic ctl_wr;
	logic cause_clear_ok;
	logic wake_req;
	logic active;
	logic pulse_on;
	logic [31:0] ctl_view;

	// ----------------------------------------------------------------
	// Decode
	// ----------------------------------------------------------------
	assign wr = bus.req && bus.we;
	assign ctl_wr = wr && bus.addr == ADDR_POWER_CONTROL && ready_q;
	assign wake_req = wr && bus.addr == ADDR_BYTE_TEST && psel_q != PSEL_FULL_POWER;
	assign cause_clear_ok = ctl_wr && psel_q == PSEL_FULL_POWER;

	// Enabled event sources, frame in bit 1, energy in bit 0
	assign source = {lan_wake_event & lan_wake_enable_q,
		energy_event & energy_detect_wake_enable_q};
	assign detect = |(source & ~source_q);

	// ----------------------------------------------------------------
	// Ready flag and power state
	// ----------------------------------------------------------------
	// Settle count after reset or wake before the device is accessible
	always_ff @(posedge bus.mclk) begin
		if (!bus.reset_n) begin
			settle_q <= '0;
			ready_q <= CTRL_BIT_RESET;
		end else if (ctl_wr && bus.wdata[POS_PSEL +: 2] != PSEL_FULL_POWER
				&& bus.wdata[POS_PSEL +: 2] != PSEL_RESERVED) begin
			settle_q <= '0;
			ready_q <= 1'b0;
		end else if (psel_q == PSEL_FULL_POWER && !ready_q) begin
			if (settle_q == SW'(SETTLE)) begin
				ready_q <= 1'b1;
			end else begin
				settle_q <= settle_q + 1'b1;
			end
		end
	end

	// Power state select clears itself on a byte test wake
	always_ff @(posedge bus.mclk) begin
		if (!bus.reset_n) begin
			psel_q <= PSEL_FULL_POWER;
		end else if (wake_req) begin
			psel_q <= PSEL_FULL_POWER;
		end else if (ctl_wr && bus.wdata[POS_PSEL +: 2] != PSEL_RESERVED) begin
			psel_q <= bus.wdata[POS_PSEL +: 2];
		end
	end

	// ----------------------------------------------------------------
	// Configuration bits
	// ----------------------------------------------------------------
	always_ff @(posedge bus.mclk) begin
		if (!bus.reset_n) begin
			lan_wake_enable_q <= CTRL_BIT_RESET;
			energy_detect_wake_enable_q <= CTRL_BIT_RESET;
			wake_output_buffer_type_q <= CTRL_BIT_RESET;
			wake_output_pulse_select_q <= CTRL_BIT_RESET;
			wake_output_polarity_q <= CTRL_BIT_RESET;
			wake_output_enable_q <= CTRL_BIT_RESET;
		end else if (ctl_wr) begin
			lan_wake_enable_q <= bus.wdata[POS_LAN_WAKE_ENABLE];
			energy_detect_wake_enable_q <= bus.wdata[POS_ENERGY_DETECT_WAKE_ENABLE];
			wake_output_buffer_type_q <= bus.wdata[POS_BUF_TYPE];
			wake_output_pulse_select_q <= bus.wdata[POS_PULSE_SEL];
			wake_output_polarity_q <= bus.wdata[POS_POLARITY];
			wake_output_enable_q <= bus.wdata[POS_OUT_EN];
		end
	end

	// ----------------------------------------------------------------
	// Wake cause status
	// ----------------------------------------------------------------
	// Live sources set their bit and win over a clear in the same cycle
	always_comb begin
		wake_cause_status_d = wake_cause_status_q;
		if (cause_clear_ok) begin
			wake_cause_status_d = wake_cause_status_q & ~bus.wdata[POS_CAUSE +: 2];
		end
		if (source[1]) begin
			wake_cause_status_d = wake_cause_status_d | CAUSE_FRAME;
		end
		if (source[0]) begin
			wake_cause_status_d = wake_cause_status_d | CAUSE_ENERGY;
		end
	end

	always_ff @(posedge bus.mclk) begin
		if (!bus.reset_n) begin
			wake_cause_status_q <= CAUSE_RESET;
			source_q <= 2'h0;
		end else begin
			wake_cause_status_q <= wake_cause_status_d;
			source_q <= source;
		end
	end

	// ----------------------------------------------------------------
	// Wake output shaping
	// ----------------------------------------------------------------
	// Causes still backed by their enables keep the output alive
	assign armed = wake_cause_status_q & {lan_wake_enable_q, energy_detect_wake_enable_q};
	// Same test on the next cause value, so the very first event can load the timer
	assign armed_d = wake_cause_status_d & {lan_wake_enable_q, energy_detect_wake_enable_q};

	// Pulse timer restarts only once idle, so a new event never stretches a pulse; losing every armed cause ends it early
	always_ff @(posedge bus.mclk) begin
		if (!bus.reset_n) begin
			pulse_q <= '0;
		end else if (armed_d == 2'h0) begin
			pulse_q <= '0;
		end else if (pulse_q != '0) begin
			pulse_q <= pulse_q - 1'b1;
		end else if (detect && wake_output_pulse_select_q) begin
			pulse_q <= PW'(PULSE_CYCLES);
		end
	end

	assign pulse_on = pulse_q != '0;
	assign active = wake_output_pulse_select_q ? (pulse_on && armed != 2'h0) : (armed != 2'h0);

	// Pin drive: open drain pulls low only, push-pull follows polarity
	always_comb begin
		if (!wake_output_enable_q) begin
			bus.wake_oe = 1'b0;
			bus.wake_out = 1'b0;
		end else if (!wake_output_buffer_type_q) begin
			bus.wake_oe = active;
			bus.wake_out = 1'b0;
		end else begin
			bus.wake_oe = 1'b1;
			bus.wake_out = wake_output_polarity_q ? active : !active;
		end
	end

	// Interrupt ignores the external output enable
	assign bus.wake_interrupt = armed != 2'h0;

	// ----------------------------------------------------------------
	// Read path and soft reset strobe
	// ----------------------------------------------------------------
	always_comb begin
		ctl_view = 32'h0;
		ctl_view[POS_PSEL +: 2] = psel_q;
		ctl_view[POS_LAN_WAKE_ENABLE] = lan_wake_enable_q;
		ctl_view[POS_ENERGY_DETECT_WAKE_ENABLE] = energy_detect_wake_enable_q;
		ctl_view[POS_BUF_TYPE] = wake_output_buffer_type_q;
		ctl_view[POS_CAUSE +: 2] = wake_cause_status_q;
		ctl_view[POS_PULSE_SEL] = wake_output_pulse_select_q;
		ctl_view[POS_POLARITY] = wake_output_polarity_q;
		ctl_view[POS_OUT_EN] = wake_output_enable_q;
		ctl_view[POS_READY] = ready_q;
	end

	// Every request is answered one cycle later; power control in any state
	always_ff @(posedge bus.mclk) begin
		if (!bus.reset_n) begin
			ack_q <= 1'b0;
			rdata_q <= 32'h0;
		end else begin
			ack_q <= bus.req;
			if (bus.req && !bus.we) begin
				unique case (bus.addr)
					ADDR_POWER_CONTROL: rdata_q <= ctl_view;
					ADDR_HW_CONFIG: rdata_q <= hw_config_in;
					ADDR_BYTE_TEST: rdata_q <= BYTE_TEST_VALUE;
					default: rdata_q <= 32'h0;
				endcase
			end
		end
	end

	// Soft reset strobe from a hardware config write when accessible
	always_ff @(posedge bus.mclk) begin
		if (!bus.reset_n) begin
			soft_reset_q <= 1'b0;
		end else begin
			soft_reset_q <= wr && ready_q && bus.addr == ADDR_HW_CONFIG && bus.wdata[POS_SOFT_RESET];
		end
	end

	assign bus.ack = ack_q;
	assign bus.rdata = rdata_q;
	assign power_state_select = psel_q;
	assign soft_reset_request = soft_reset_q;
endmodule

// ### logic/wk_host.sv
/*
 * Host end: turns user commands into bus requests and keeps the access
 * discipline that the controller expects while it is not ready.
 * Assumes the controller answers every request one cycle after it.
 */
`timescale 1ns/1ps
module wk_host (
	wk_bus_if.host bus,
	input wire logic cmd_valid,
	input wire logic cmd_write,
	input wire logic [7:0] cmd_addr,
	input wire logic [31:0] cmd_wdata,
	output logic cmd_ready,
	output logic rsp_valid,
	output logic rsp_refused,
	output logic [31:0] rsp_data,
	output logic device_ready,
	output logic wake_seen
);
	import wk_pkg::*;

	typedef enum logic [1:0] {
		ST_IDLE = 2'b01,
		ST_WAIT = 2'b10
	} wk_host_state_type;

	wk_host_state_type state_q;
	logic req_q;
	logic we_q;
	logic [7:0] addr_q;
	logic [31:0] wdata_q;
	logic rsp_valid_q;
	logic rsp_refused_q;
	logic [31:0] rsp_data_q;
	logic ready_q;
	logic allowed;

	// While not ready: reads of config or power control, byte test writes
	assign allowed = ready_q
		|| (!cmd_write && (cmd_addr == ADDR_POWER_CONTROL || cmd_addr == ADDR_HW_CONFIG))
		|| (cmd_write && cmd_addr == ADDR_BYTE_TEST);

	// Request sequencing
	always_ff @(posedge bus.mclk) begin
		if (!bus.reset_n) begin
			state_q <= ST_IDLE;
			req_q <= 1'b0;
			we_q <= 1'b0;
			addr_q <= 8'h0;
			wdata_q <= 32'h0;
			rsp_valid_q <= 1'b0;
			rsp_refused_q <= 1'b0;
			rsp_data_q <= 32'h0;
		end else begin
			req_q <= 1'b0;
			rsp_valid_q <= 1'b0;
			unique case (state_q)
				ST_IDLE: begin
					if (cmd_valid && allowed) begin
						req_q <= 1'b1;
						we_q <= cmd_write;
						addr_q <= cmd_addr;
						wdata_q <= cmd_wdata;
						state_q <= ST_WAIT;
					end else if (cmd_valid) begin
						rsp_valid_q <= 1'b1;
						rsp_refused_q <= 1'b1;
						rsp_data_q <= 32'h0;
					end
				end
				ST_WAIT: begin
					if (bus.ack) begin
						rsp_valid_q <= 1'b1;
						rsp_refused_q <= 1'b0;
						rsp_data_q <= we_q ? 32'h0 : bus.rdata;
						state_q <= ST_IDLE;
					end
				end
			endcase
		end
	end

	// Ready knowledge follows each power control read; lost on power down
	always_ff @(posedge bus.mclk) begin
		if (!bus.reset_n) begin
			ready_q <= 1'b0;
		end else if (state_q == ST_WAIT && bus.ack && !we_q && addr_q == ADDR_POWER_CONTROL) begin
			ready_q <= bus.rdata[POS_READY];
		end else if (req_q && we_q && addr_q == ADDR_POWER_CONTROL
				&& wdata_q[POS_PSEL +: 2] != PSEL_FULL_POWER) begin
			ready_q <= 1'b0;
		end
	end

	// Wake interrupt seen, registered; the wake line is not sampled
	always_ff @(posedge bus.mclk) begin
		if (!bus.reset_n) begin
			wake_seen <= 1'b0;
		end else begin
			wake_seen <= bus.wake_interrupt;
		end
	end

	assign cmd_ready = state_q == ST_IDLE;
	assign bus.req = req_q;
	assign bus.we = we_q;
	assign bus.addr = addr_q;
	assign bus.wdata = wdata_q;
	assign rsp_valid = rsp_valid_q;
	assign rsp_refused = rsp_refused_q;
	assign rsp_data = rsp_data_q;
	assign device_ready = ready_q;
endmodule

// ### dv/wk_bus_properties.sv
/*
 * Assertions on the host bus and the wake pin between the two ends.
 * Assumes it sits beside the interface, fed with its signals by name.
 */
`timescale 1ns/1ps
module wk_bus_properties
	import wk_pkg::*;
#(
	parameter int PULSE_CYCLES = WAKE_PULSE_CYCLES,
	parameter int SETTLE = 16
) (
	input wire logic mclk,
	input wire logic reset_n,
	input wire logic req,
	input wire logic we,
	input wire logic [7:0] addr,
	input wire logic ack,
	input wire logic [31:0] rdata,
	input wire logic wake_out,
	input wire logic wake_oe,
	input wire logic wake_interrupt
);
	logic [31:0] cfg_q;
	logic fresh_q;
	logic rd_q;
	logic act;
	int run_q;
	int since_q;

	default clocking @(posedge mclk); endclocking
	default disable iff (!reset_n);

	// Shadow of the control word, trusted until the next write
	always_ff @(posedge mclk) begin
		rd_q <= reset_n && req && !we && addr == ADDR_POWER_CONTROL;
		if (!reset_n || (req && we))
			fresh_q <= 1'b0;
		else if (ack && rd_q)
			fresh_q <= 1'b1;
		if (ack && rd_q)
			cfg_q <= rdata;
	end

	// Pin active level as the shadow says
	assign act = fresh_q && (cfg_q[6] ? (wake_oe && wake_out == cfg_q[2]) : wake_oe);

	// Length of the current pulse and time since reset
	always_ff @(posedge mclk) begin
		if (!reset_n)
			since_q <= 0;
		else if (since_q < 255)
			since_q <= since_q + 1;
		if (!reset_n || !(act && cfg_q[3]))
			run_q <= 0;
		else
			run_q <= run_q + 1;
	end

	ack_follows_req_a: assert property (req |=> ack) else $error("request not answered");
	ack_needs_req_a: assert property (ack |-> $past(req)) else $error("answer without request");
	rdata_holds_a: assert property (!(req && !we) |=> $stable(rdata)) else $error("read data moved");
	ready_late_a: assert property (ack && rd_q && since_q <= SETTLE |-> !rdata[0])
		else $error("ready too early");
	oe_gated_a: assert property (fresh_q && !cfg_q[1] |-> !wake_oe) else $error("pin driven while off");
	open_drain_low_a: assert property (fresh_q && !cfg_q[6] && wake_oe |-> !wake_out)
		else $error("open drain drove high");
	push_pull_on_a: assert property (fresh_q && cfg_q[1] && cfg_q[6] |-> wake_oe) else $error("pin not driven");
	static_level_a: assert property (fresh_q && cfg_q[1] && cfg_q[6] && !cfg_q[3] |->
		wake_out == (cfg_q[2] ? wake_interrupt : !wake_interrupt)) else $error("static level wrong");
	pulse_bounded_a: assert property (run_q <= PULSE_CYCLES) else $error("pulse too long");
	pin_needs_irq_a: assert property (act |-> wake_interrupt) else $error("pin active without cause");
endmodule

// ### dv/wake_event_status_and_indication_bench.sv
/*
 * Self-checking bench: host and controller ends joined by the bus.
 * Assumes the package, interface and both ends are compiled first.
 */
`timescale 1ns/1ps
module wake_event_status_and_indication_bench;
	import wk_pkg::*;
	localparam int PULSE = 20;
	localparam int SETTLE = 4;
	logic mclk, reset_n, cmd_valid, cmd_write, cmd_ready, rsp_valid, rsp_refused, device_ready;
	logic wake_seen, lan_ev, energy_ev, soft_reset_request, refused;
	logic [7:0] cmd_addr;
	logic [31:0] cmd_wdata, rsp_data, hardware_config_register, got;
	logic [1:0] psel;
	logic [15:0] lfsr_q;
	int n_fail = 0;
	int checks_done = 0;
	int n_soft_reset_request = 0;
	int n;

	wk_bus_if wk_bus_if_i (.mclk(mclk), .reset_n(reset_n));
	wk_device #(.PULSE_CYCLES(PULSE), .SETTLE(SETTLE)) wk_device_i (.bus(wk_bus_if_i.device),
		.lan_wake_event(lan_ev), .energy_event(energy_ev), .hw_config_in(hardware_config_register),
		.power_state_select(psel), .soft_reset_request(soft_reset_request));
	wk_host wk_host_i (.bus(wk_bus_if_i.host), .cmd_valid(cmd_valid), .cmd_write(cmd_write),
		.cmd_addr(cmd_addr), .cmd_wdata(cmd_wdata), .cmd_ready(cmd_ready), .rsp_valid(rsp_valid),
		.rsp_refused(rsp_refused), .rsp_data(rsp_data), .device_ready(device_ready), .wake_seen(wake_seen));
	wk_bus_properties #(.PULSE_CYCLES(PULSE), .SETTLE(SETTLE)) wk_bus_properties_i (.mclk(mclk),
		.reset_n(reset_n), .req(wk_bus_if_i.req), .we(wk_bus_if_i.we), .addr(wk_bus_if_i.addr),
		.ack(wk_bus_if_i.ack), .rdata(wk_bus_if_i.rdata), .wake_out(wk_bus_if_i.wake_out),
		.wake_oe(wk_bus_if_i.wake_oe), .wake_interrupt(wk_bus_if_i.wake_interrupt));

	// Random source
	function automatic logic [15:0] lfsr(input logic [15:0] v);
		return {v[14:0], v[15] ^ v[13] ^ v[12] ^ v[10]};
	endfunction

	// Control word expected in full power with ready set
	function automatic logic [31:0] exp_ctl(input logic [31:0] c, input logic [1:0] cause);
		return (c & 32'h0000_034e) | {26'h0, cause, 4'h1};
	endfunction

	task automatic chk(input logic [31:0] g, input logic [31:0] e, input string m);
		checks_done++;
		if (g !== e) begin
			n_fail++;
			$display("[FAIL] %0t %s got %h exp %h", $time, m, g, e);
		end
	endtask

	task automatic conclude;
		$display("checks %0d failures %0d", checks_done, n_fail);
		if (n_fail == 0 && checks_done > 0)
			$display("TEST PASSED");
		else
			$display("TEST FAILED");
		$finish;
	endtask

	// One user command, held until taken, then wait for its response
	task automatic cmd(input logic w, input logic [7:0] a, input logic [31:0] d);
		int k;
		@(negedge mclk);
		cmd_valid = 1'b1;
		cmd_write = w;
		cmd_addr = a;
		cmd_wdata = d;
		k = 0;
		while (cmd_ready !== 1'b1 && k < 50) begin
			@(negedge mclk);
			k++;
		end
		@(negedge mclk);
		cmd_valid = 1'b0;
		k = 0;
		while (rsp_valid !== 1'b1 && k < 10) begin
			@(negedge mclk);
			k++;
		end
		chk(32'(k < 10), 32'h1, "no response");
		refused = rsp_refused;
		got = rsp_data;
	endtask

	task automatic poll_ready;
		int k;
		k = 0;
		got = '0;
		while (got[0] !== 1'b1 && k < 40) begin
			cmd(1'b0, ADDR_POWER_CONTROL, '0);
			k++;
		end
		@(negedge mclk);
		chk(32'(device_ready), 32'h1, "host view of ready");
	endtask

	// Static event through one setting of the pin, then clear
	task automatic ev_case(input logic [31:0] c, input logic lan, input logic idle, input logic act);
		cmd(1'b1, ADDR_POWER_CONTROL, c);
		chk(32'(wk_bus_if_i.wake_level), 32'(idle), "idle level");
		lfsr_q = lfsr(lfsr_q);
		repeat (int'(lfsr_q[2:0])) @(negedge mclk);
		if (lan)
			lan_ev = 1'b1;
		else
			energy_ev = 1'b1;
		repeat (3) @(negedge mclk);
		chk(32'(wk_bus_if_i.wake_level), 32'(act), "active level");
		chk(32'(wake_seen), 32'h1, "interrupt");
		cmd(1'b0, ADDR_POWER_CONTROL, '0);
		chk(got, exp_ctl(c, lan ? 2'h2 : 2'h1), "cause");
		lan_ev = 1'b0;
		energy_ev = 1'b0;
		cmd(1'b1, ADDR_POWER_CONTROL, c | 32'h30);
		chk(32'(wk_bus_if_i.wake_level), 32'(idle), "released level");
		cmd(1'b0, ADDR_POWER_CONTROL, '0);
		chk(got, exp_ctl(c, 2'h0), "cleared");
	endtask

	// Clock
	initial begin
		mclk = 1'b0;
		forever #50 mclk = ~mclk;
	end

	// Soft reset pulses
	always @(posedge mclk) begin
		if (soft_reset_request === 1'b1)
			n_soft_reset_request++;
	end

	// Watchdog
	initial begin
		repeat (20000) @(posedge mclk);
		$display("[FAIL] %0t watchdog expired", $time);
		n_fail++;
		conclude();
	end

	// Main sequence
	initial begin
		reset_n = 1'b0;
		cmd_valid = 1'b0;
		cmd_write = 1'b0;
		cmd_addr = '0;
		cmd_wdata = '0;
		lan_ev = 1'b0;
		energy_ev = 1'b0;
		lfsr_q = 16'hae7f;
		hardware_config_register = {lfsr_q, lfsr(lfsr_q)};
		repeat (16) @(negedge mclk);
		reset_n = 1'b1;
		cmd(1'b0, ADDR_POWER_CONTROL, '0);
		chk(got, 32'h0, "word before ready");
		cmd(1'b0, 8'h50, '0);
		chk(32'(refused), 32'h1, "early read");
		cmd(1'b1, ADDR_POWER_CONTROL, 32'h2);
		chk(32'(refused), 32'h1, "early write");
		cmd(1'b0, ADDR_HW_CONFIG, '0);
		chk(got, hardware_config_register, "config read");
		poll_ready();
		chk(got, 32'h1, "reset word");
		cmd(1'b1, ADDR_HW_CONFIG, 32'h1);
		chk(32'(n_soft_reset_request), 32'h1, "soft reset");
		ev_case(32'h146, 1'b0, 1'b0, 1'b1);
		ev_case(32'h242, 1'b1, 1'b1, 1'b0);
		ev_case(32'h144, 1'b0, 1'b1, 1'b1);
		ev_case(32'h106, 1'b0, 1'b1, 1'b0);
		cmd(1'b1, ADDR_POWER_CONTROL, 32'h346);
		energy_ev = 1'b1;
		lan_ev = 1'b1;
		repeat (3) @(negedge mclk);
		cmd(1'b0, ADDR_POWER_CONTROL, '0);
		chk(got, exp_ctl(32'h346, 2'h3), "both causes");
		cmd(1'b1, ADDR_POWER_CONTROL, 32'h356);
		cmd(1'b0, ADDR_POWER_CONTROL, '0);
		chk(got, exp_ctl(32'h346, 2'h3), "source still live");
		energy_ev = 1'b0;
		cmd(1'b1, ADDR_POWER_CONTROL, 32'h356);
		cmd(1'b1, ADDR_POWER_CONTROL, 32'h346);
		cmd(1'b0, ADDR_POWER_CONTROL, '0);
		chk(got, exp_ctl(32'h346, 2'h2), "one cleared");
		cmd(1'b1, ADDR_POWER_CONTROL, 32'h146);
		chk(32'(wk_bus_if_i.wake_level), 32'h0, "enable dropped");
		lan_ev = 1'b0;
		cmd(1'b1, ADDR_POWER_CONTROL, 32'h176);
		cmd(1'b1, ADDR_POWER_CONTROL, 32'h10e);
		cmd(1'b0, ADDR_POWER_CONTROL, '0);
		chk(got, exp_ctl(32'h10e, 2'h0), "pulse setup");
		energy_ev = 1'b1;
		n = 0;
		while (wk_bus_if_i.wake_level !== 1'b0 && n < 10) begin
			@(negedge mclk);
			n++;
		end
		n = 0;
		while (wk_bus_if_i.wake_level === 1'b0 && n < 100) begin
			n++;
			if (n == 5)
				energy_ev = 1'b0;
			if (n == 7)
				energy_ev = 1'b1;
			@(negedge mclk);
		end
		chk(32'(n), 32'(PULSE), "pulse length");
		energy_ev = 1'b0;
		cmd(1'b1, ADDR_POWER_CONTROL, 32'h13e);
		for (int p = 1; p < 3; p++) begin
			cmd(1'b1, ADDR_POWER_CONTROL, 32'(p) << 12);
			chk(32'(psel), 32'(p), "state select");
			cmd(1'b0, ADDR_POWER_CONTROL, '0);
			chk(got, 32'(p) << 12, "low power word");
			cmd(1'b1, 8'h50, '0);
			chk(32'(refused), 32'h1, "write while asleep");
			lfsr_q = lfsr(lfsr_q);
			cmd(1'b1, ADDR_BYTE_TEST, {lfsr_q, ~lfsr_q});
			poll_ready();
			chk(32'(psel), 32'h0, "woken state");
		end
		cmd(1'b1, ADDR_POWER_CONTROL, 32'h3000);
		cmd(1'b0, ADDR_POWER_CONTROL, '0);
		chk(got, 32'h1, "reserved state");
		conclude();
	end
endmodule
